// ==== design/cfgr_responder.sv ====
// Added by the designer: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
`include "cfgr_consts.svh"
// Function
// RL1 - one request configuration command returns exactly one 16-bit word
// RL2 - command bits 11 to 8 select the returned word
// RL3 - modifier 0000 returns the general configuration flag word
// RL4 - modifier 0001 returns the fixed cylinder count from model strap
// RL5 - modifier 0010 returns zero, no removable cylinders
// RL6 - modifier 0011 returns zero upper byte, head count lower byte
// RL7 - modifier 0100 returns 31320 bytes per track
// RL8 - modifier 0101 returns 31320 divided by sectors per track
// RL9 - modifier 0110 returns sectors per track, strap default or set value
// RL10 - modifier 0111 returns 18 upper byte and 24 lower byte
// RL11 - modifier 1000 returns zero upper byte and 11 low
// RL12 - modifier 1001 returns 15, the count of vendor status words
// RL13 - modifiers 1010 to 1110 are invalid, no word returned
// RL14 - modifier 1111 returns the vendor identification code
// RL15 - general word bits 13,12,6,3 high; 15,11,7,0 low
// RL16 - general word bit 10 high, bits 9 and 8 low
// RL17 - general word bit 5 shows the motor start option
// RL18 - general word bit 4 zero, command complete kept on head change
// RL19 - exactly one of bits 2 and 1 set, matching sector mode strap
// RL20 - general word bit 14 zero, no speed tolerance gaps
// RL21 - controller writes zeros in sync fields
// RL22 - selected word is sent serially on the config line
// RL23 - controller waits for command complete, first after power-up delay
// RL24 - invalid command raises attention and invalid command fault
// RL25 - command complete returns after the word is fully sent
// RL26 - counts and sector mode come from static strap inputs
module cfgr_responder
  import cfgr_pkg::*;
#(
  parameter logic [15:0] VENDOR_ID = 16'h00a5, // arbitrary value
  parameter int unsigned PWRUP_CYCLES = `CFGR_PWRUP_S * `CFGR_CLK_HZ
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire cfgr_static_type strapPins,
  output logic cfgData,
  output logic cfgStrobe,
  output logic cmdComplete,
  output logic attention
);
  cfgr_state_type state;
  cfgr_static_type strapQ1, straps;
  cfgr_cmd_type cmd;
  logic awHave, wHave, doWrite, invFault, pwrDone, sptSet, divForSpt, phase;
  logic cmdAccept, cmdGo, cmdInvalid, bpsAccept, bpsGo, bpsInvalid, clrReq;
  logic modInvalid, needDiv, divDone, sendStart, sendDone, wrOk;
  logic [11:0] awAddrQ;
  logic [31:0] wDataQ, pwrCnt;
  logic [3:0] wStrbQ, bitCnt, respMod;
  logic [15:0] sptReg, sptCur, next_word, startWord, respWord, txShift;
  logic [15:0] divQuo, divDen, divResult, divisorSel;
  logic [16:0] divRem, remShift;
  logic [4:0] divCnt;

  // RL26 strap pins through two flops
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      strapQ1 <= '0;
      straps <= '0;
    end else begin
      strapQ1 <= strapPins;
      straps <= strapQ1;
    end
  end

  // write address and data capture, response
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      awready <= 1'b1;
      wready <= 1'b1;
      awHave <= 1'b0;
      wHave <= 1'b0;
      awAddrQ <= 12'h000;
      wDataQ <= 32'h00000000;
      wStrbQ <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `CFGR_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awAddrQ <= awaddr;
        awHave <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wDataQ <= wdata;
        wStrbQ <= wstrb;
        wHave <= 1'b1;
        wready <= 1'b0;
      end
      if (doWrite) begin
        awHave <= 1'b0;
        wHave <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
        bvalid <= 1'b1;
        bresp <= wrOk ? `CFGR_RESP_OKAY : `CFGR_RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // read channel, answer one cycle after the address
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `CFGR_RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= `CFGR_RESP_OKAY;
      rdata <= 32'h00000000;
      if (araddr == `CFGR_ADDR_STATUS) begin
        rdata <= {respWord, 10'h000, invFault, 2'h0, attention, (state != ST_IDLE), cmdComplete};
      end else if (araddr == `CFGR_ADDR_BPS) begin
        rdata <= {16'h0000, sptCur};
      end else if (araddr != `CFGR_ADDR_CMD && araddr != `CFGR_ADDR_CTRL) begin
        rresp <= `CFGR_RESP_SLVERR;
      end
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // write decode and command interpretation
  always_comb begin
    doWrite = awHave && wHave && !bvalid;
    cmd = cfgr_cmd_type'(wDataQ[15:0]);
    // RL2 modifier field select
    modInvalid = (cmd.modifier >= `CFGR_MOD_INV_LO) && (cmd.modifier <= `CFGR_MOD_INV_HI);
    needDiv = (cmd.modifier == `CFGR_MOD_SECT_BYTES);
    cmdAccept = 1'b0;
    bpsAccept = 1'b0;
    clrReq = 1'b0;
    wrOk = 1'b0;
    if (awAddrQ == `CFGR_ADDR_CMD) begin
      cmdAccept = doWrite && state == ST_IDLE && cmdComplete && wStrbQ[1:0] == 2'h3;
      wrOk = cmdAccept;
    end else if (awAddrQ == `CFGR_ADDR_BPS) begin
      bpsAccept = doWrite && state == ST_IDLE && cmdComplete && wStrbQ[1:0] == 2'h3;
      wrOk = bpsAccept;
    end else if (awAddrQ == `CFGR_ADDR_CTRL) begin
      clrReq = doWrite && wStrbQ[0] && wDataQ[`CFGR_CTRL_CLR_BIT];
      wrOk = 1'b1;
    end
    // RL13 invalid modifiers give no word
    cmdGo = cmdAccept && cmd.func == `CFGR_FUNC_REQCFG && !modInvalid;
    // RL24 invalid or unimplemented command
    cmdInvalid = cmdAccept && !(cmd.func == `CFGR_FUNC_REQCFG && !modInvalid);
    bpsGo = bpsAccept && wDataQ[11:0] >= `CFGR_BPS_MIN;
    bpsInvalid = bpsAccept && !bpsGo;
  end

  // answer word for the modifier
  always_comb begin
    next_word = 16'h0000;
    case (cmd.modifier)
      `CFGR_MOD_GENERAL: begin
        // RL3 RL15 RL16 RL20 RL18 general flags
        next_word = `CFGR_GEN_FIXED;
        // RL17 motor option bit
        next_word[`CFGR_GEN_MOTOR_BIT] = straps.motorOpt;
        // RL19 one sector mode bit
        next_word[`CFGR_GEN_SOFT_BIT] = straps.softSector;
        next_word[`CFGR_GEN_HARD_BIT] = !straps.softSector;
      end
      // RL4 fixed cylinders
      `CFGR_MOD_CYL_FIXED: next_word = straps.cylinders;
      // RL5 no removable cylinders
      `CFGR_MOD_CYL_REMOV: next_word = 16'h0000;
      // RL6 head count low byte
      `CFGR_MOD_HEADS: next_word = {8'h00, straps.heads};
      // RL7 track bytes
      `CFGR_MOD_TRACK_BYTES: next_word = `CFGR_TRACK_BYTES;
      `CFGR_MOD_SPT: next_word = sptCur;
      // RL10 gap minimums
      `CFGR_MOD_GAP: next_word = `CFGR_GAP_WORD;
      // RL11 sync field minimum
      `CFGR_MOD_SYNC: next_word = `CFGR_SYNC_WORD;
      // RL12 vendor status count
      `CFGR_MOD_VU_COUNT: next_word = `CFGR_VU_WORDS;
      // RL14 vendor identity
      `CFGR_MOD_VENDOR: next_word = VENDOR_ID;
      default: next_word = 16'h0000;
    endcase
  end

  // sequencing strobes
  always_comb begin
    // RL9 sectors per track, strap default unless set
    sptCur = sptSet ? sptReg : {8'h00, straps.sptDefault};
    divisorSel = (state == ST_IDLE && bpsGo) ? {4'h0, wDataQ[11:0]} : sptCur;
    divDone = state == ST_DIVIDE && divCnt == `CFGR_DIV_STEPS;
    divResult = (divDen == 16'h0000) ? 16'h0000 : divQuo;
    sendStart = (state == ST_IDLE && cmdGo && !needDiv) || (divDone && !divForSpt);
    startWord = (state == ST_IDLE) ? next_word : divResult;
    sendDone = state == ST_SEND && phase && bitCnt == `CFGR_LAST_BIT;
    remShift = {divRem[15:0], divQuo[15]};
  end

  // main sequencer
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      divForSpt <= 1'b0;
      sptSet <= 1'b0;
      sptReg <= 16'h0000;
      respMod <= 4'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (cmdGo) begin
            respMod <= cmd.modifier;
            divForSpt <= 1'b0;
            state <= needDiv ? ST_DIVIDE : ST_SEND;
          end else if (bpsGo) begin
            divForSpt <= 1'b1;
            state <= ST_DIVIDE;
          end
        end
        ST_DIVIDE: begin
          if (divDone) begin
            state <= divForSpt ? ST_IDLE : ST_SEND;
            if (divForSpt) begin
              // RL9 spt from set bytes per sector
              sptReg <= divResult;
              sptSet <= 1'b1;
            end
          end
        end
        ST_SEND: begin
          if (sendDone) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
  // RL8 restoring divide of track bytes
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      divRem <= 17'h00000;
      divQuo <= 16'h0000;
      divDen <= 16'h0000;
      divCnt <= `CFGR_DIV_STEPS;
    end else if (state == ST_IDLE && (bpsGo || (cmdGo && needDiv))) begin
      divRem <= 17'h00000;
      divQuo <= `CFGR_TRACK_BYTES;
      divDen <= divisorSel;
      divCnt <= 5'h00;
    end else if (divCnt != `CFGR_DIV_STEPS) begin
      divCnt <= divCnt + 5'h01;
      if (remShift >= {1'b0, divDen}) begin
        divRem <= remShift - {1'b0, divDen};
        divQuo <= {divQuo[14:0], 1'b1};
      end else begin
        divRem <= remShift;
        divQuo <= {divQuo[14:0], 1'b0};
      end
    end
  end
  // RL22 serial send, msb first, strobe in second cycle of each bit
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      txShift <= 16'h0000;
      respWord <= 16'h0000;
      bitCnt <= 4'h0;
      phase <= 1'b0;
      cfgData <= 1'b0;
      cfgStrobe <= 1'b0;
    end else if (sendStart) begin
      // RL1 one word latched per request
      txShift <= startWord;
      respWord <= startWord;
      bitCnt <= 4'h0;
      phase <= 1'b0;
      cfgData <= startWord[15];
      cfgStrobe <= 1'b0;
    end else if (state == ST_SEND) begin
      phase <= !phase;
      cfgStrobe <= !phase;
      if (phase) begin
        txShift <= {txShift[14:0], 1'b0};
        cfgData <= sendDone ? 1'b0 : txShift[14];
        bitCnt <= bitCnt + 4'h1;
      end
    end
  end
  // power-up delay before first command complete
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pwrCnt <= 32'h00000000;
      pwrDone <= 1'b0;
    end else if (!pwrDone) begin
      pwrCnt <= pwrCnt + 32'h00000001;
      pwrDone <= (pwrCnt == 32'(PWRUP_CYCLES - 1));
    end
  end
  // command complete, attention and fault flags
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmdComplete <= 1'b0;
      attention <= 1'b0;
      invFault <= 1'b0;
    end else begin
      if (!pwrDone && pwrCnt == 32'(PWRUP_CYCLES - 1)) begin
        cmdComplete <= 1'b1;
      end else if (cmdGo || bpsGo) begin
        cmdComplete <= 1'b0;
      end else if (sendDone || (divDone && divForSpt)) begin
        // RL25 complete again after the word
        cmdComplete <= 1'b1;
      end
      // RL24 set wins over software clear
      if (cmdInvalid || bpsInvalid) begin
        attention <= 1'b1;
        invFault <= 1'b1;
      end else if (clrReq) begin
        attention <= 1'b0;
        invFault <= 1'b0;
      end
    end
  end

  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  logic [5:0] sendCycles;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sendCycles <= 6'h00;
    end else begin
      sendCycles <= (state == ST_SEND) ? sendCycles + 6'h01 : 6'h00;
    end
  end
  sequence seqBadCmd;
    state == ST_IDLE && cmdInvalid;
  endsequence
  sequence seqFlagsUp;
    attention && invFault && state == ST_IDLE;
  endsequence
  sequence seqSendEnd;
    state == ST_SEND && sendDone;
  endsequence
  sequence seqReady;
    state == ST_IDLE && cmdComplete;
  endsequence
  AST_INVALID_FLAGS: assert property (seqBadCmd |=> seqFlagsUp) // RL24
    else $error("invalid modifier did not raise attention and fault");
  AST_SEND_LENGTH: assert property (seqSendEnd |-> sendCycles == 6'h1f) // RL1
    else $error("word not sent in 32 cycles");
  AST_CC_AFTER_SEND: assert property (seqSendEnd |=> seqReady) // RL25
    else $error("command complete not restored after send");
  AST_CC_LOW_BUSY: assert property (state != ST_IDLE |-> !cmdComplete) // RL23
    else $error("command complete high while busy");
  AST_GEN_FLAGS: assert property (state == ST_SEND && respMod == `CFGR_MOD_GENERAL
      |-> (respWord & 16'hffd9) == `CFGR_GEN_FIXED) // RL15
    else $error("general word fixed flags wrong");
  AST_SECTOR_MODE: assert property (state == ST_SEND && respMod == `CFGR_MOD_GENERAL
      |-> respWord[2] != respWord[1] && respWord[2] == straps.softSector) // RL19
    else $error("sector mode bits wrong");
  AST_HEADS_UPPER: assert property (state == ST_SEND && respMod == `CFGR_MOD_HEADS
      |-> respWord == {8'h00, straps.heads}) // RL6
    else $error("head count word wrong");
  AST_SYNC_WORD: assert property (state == ST_SEND && respMod == `CFGR_MOD_SYNC
      |-> respWord == 16'h000b) // RL11
    else $error("sync field word wrong");
  AST_DIV_RESULT: assert property (divDone && divDen != 16'h0000
      |-> {16'h0000, divQuo} * {16'h0000, divDen} <= 32'h00007a58
      && ({16'h0000, divQuo} + 32'h1) * {16'h0000, divDen} > 32'h00007a58) // RL8
    else $error("bytes per sector quotient wrong");
  AST_FIRST_BIT: assert property ($rose(state == ST_SEND)
      |-> cfgData == respWord[15] && !cfgStrobe ##1 cfgStrobe) // RL22
    else $error("first serial bit wrong");
endmodule

// ==== include/cfgr_consts.svh ====
`ifndef CFGR_CONSTS_SVH
`define CFGR_CONSTS_SVH
// register byte addresses
`define CFGR_ADDR_CMD 12'h000
`define CFGR_ADDR_STATUS 12'h004
`define CFGR_ADDR_CTRL 12'h008
`define CFGR_ADDR_BPS 12'h00c
// bus responses
`define CFGR_RESP_OKAY 2'h0
`define CFGR_RESP_SLVERR 2'h2
// command function and modifier codes
`define CFGR_FUNC_REQCFG 4'h3
`define CFGR_MOD_GENERAL 4'h0
`define CFGR_MOD_CYL_FIXED 4'h1
`define CFGR_MOD_CYL_REMOV 4'h2
`define CFGR_MOD_HEADS 4'h3
`define CFGR_MOD_TRACK_BYTES 4'h4
`define CFGR_MOD_SECT_BYTES 4'h5
`define CFGR_MOD_SPT 4'h6
`define CFGR_MOD_GAP 4'h7
`define CFGR_MOD_SYNC 4'h8
`define CFGR_MOD_VU_COUNT 4'h9
`define CFGR_MOD_INV_LO 4'ha
`define CFGR_MOD_INV_HI 4'he
`define CFGR_MOD_VENDOR 4'hf
// general word: bits 13,12,10,6,3 set
`define CFGR_GEN_FIXED 16'h3448
`define CFGR_GEN_MOTOR_BIT 5
`define CFGR_GEN_SOFT_BIT 2
`define CFGR_GEN_HARD_BIT 1
// constant answers
`define CFGR_TRACK_BYTES 16'h7a58
`define CFGR_GAP_WORD 16'h1218
`define CFGR_SYNC_WORD 16'h000b
`define CFGR_VU_WORDS 16'h000f
`define CFGR_BPS_MIN 12'h052
// status and control bits
`define CFGR_STS_CC_BIT 0
`define CFGR_STS_BUSY_BIT 1
`define CFGR_STS_ATTN_BIT 2
`define CFGR_STS_INVF_BIT 5
`define CFGR_CTRL_CLR_BIT 0
// timing
`define CFGR_CLK_HZ 20000000
`define CFGR_PWRUP_S 35
`define CFGR_DIV_STEPS 5'h10
`define CFGR_LAST_BIT 4'hf
`endif

// ==== include/cfgr_pkg.sv ====
package cfgr_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_DIVIDE, ST_SEND} cfgr_state_type;
  // per model / installation straps
  typedef struct packed {
    logic [15:0] cylinders;
    logic [7:0] heads;
    logic softSector;
    logic motorOpt;
    logic [7:0] sptDefault;
  } cfgr_static_type;
  // received command word
  typedef struct packed {
    logic [3:0] func;
    logic [3:0] modifier;
    logic [7:0] param;
  } cfgr_cmd_type;
endpackage

// ==== verif/cfgr_ctrl_model.sv ====
`timescale 1ns/100ps
module cfgr_ctrl_model (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic cfgData,
  input wire logic cfgStrobe,
  output logic [15:0] rxWord,
  output logic [15:0] rxBits
);
  // model sends no write data, so its sync fields stay zero
  // shift in one bit per strobe, msb first
  // serial word capture
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rxWord <= 16'h0000;
      rxBits <= 16'h0000;
    end else if (cfgStrobe) begin
      rxWord <= {rxWord[14:0], cfgData};
      rxBits <= rxBits + 16'h0001;
    end
  end
endmodule

// ==== verif/disk_config_response_generator_bench.sv ====
`timescale 1ns/100ps
`include "cfgr_consts.svh"
module disk_config_response_generator_bench
  import cfgr_pkg::*;
;
  localparam logic [15:0] VID = 16'h005c; // arbitrary value
  logic core_clk, rst_b, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, cfgData, cfgStrobe, cmdComplete, attention;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic [15:0] rxWord, rxBits, spt;
  cfgr_static_type strapPins;
  int error_cnt = 0;
  int total_checks = 0;

  cfgr_responder #(.VENDOR_ID(VID), .PWRUP_CYCLES(16)) dut_u (
    .core_clk(core_clk), .rst_b(rst_b), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .strapPins(strapPins), .cfgData(cfgData), .cfgStrobe(cfgStrobe),
    .cmdComplete(cmdComplete), .attention(attention));

  cfgr_ctrl_model ctrl_u (.core_clk(core_clk), .rst_b(rst_b), .cfgData(cfgData),
    .cfgStrobe(cfgStrobe), .rxWord(rxWord), .rxBits(rxBits));

  // clock generation
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // one write, address and data offered together
  task automatic axiWrite(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge core_clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid || n > 300) break;
    end
    if (!bvalid) error_cnt++;
    r = bresp;
    bready <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic axiRead(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge core_clk);
      n++;
      if (arready) arvalid <= 1'b0;
      if (rvalid || n > 300) break;
    end
    if (!rvalid) error_cnt++;
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic waitReady();
    int n;
    n = 0;
    while (!cmdComplete && n < 2000) begin
      @(posedge core_clk);
      n++;
    end
    if (!cmdComplete) error_cnt++;
  endtask

  function automatic logic [15:0] expWord(input logic [3:0] m);
    case (m)
      4'h0: expWord = 16'h3448 | {10'h000, strapPins.motorOpt, 2'b00,
        strapPins.softSector, !strapPins.softSector, 1'b0};
      4'h1: expWord = 16'h0584;
      4'h2: expWord = 16'h0000;
      4'h3: expWord = {8'h00, 8'h0f};
      4'h4: expWord = 16'd31320;
      4'h5: expWord = 16'(32'd31320 / spt);
      4'h6: expWord = spt;
      4'h7: expWord = {8'd18, 8'd24};
      4'h8: expWord = 16'd11;
      4'h9: expWord = 16'd15;
      default: expWord = VID;
    endcase
  endfunction

  task automatic reqCfg(input logic [3:0] m);
    logic [15:0] b;
    logic [1:0] r;
    b = rxBits;
    axiWrite(`CFGR_ADDR_CMD, {16'h0000, 4'h3, m, 8'h00}, r);
    chk(r, `CFGR_RESP_OKAY);
    waitReady();
    chk(cmdComplete, 1'b1);
    chk(rxWord, expWord(m));
    chk(rxBits - b, 16'd16);
    chk(attention, 1'b0);
  endtask

  task automatic test_reset();
    chk({awready, wready, arready, bvalid, rvalid}, 5'b11100);
    chk({cmdComplete, attention, cfgStrobe}, 3'b000);
  endtask

  task automatic test_early();
    axiWrite(`CFGR_ADDR_CMD, 32'h00003000, rs);
    chk(rs, `CFGR_RESP_SLVERR);
    waitReady();
    chk(rxBits, 16'h0000);
  endtask

  task automatic test_words();
    // every valid modifier, strap sectors per track
    for (int m = 0; m < 16; m++) begin
      if (m < 10 || m == 15) reqCfg(4'(m));
    end
  endtask

  task automatic test_invalid();
    logic [15:0] b;
    for (int m = 10; m < 15; m++) begin
      b = rxBits;
      axiWrite(`CFGR_ADDR_CMD, {16'h0000, 4'h3, 4'(m), 8'h00}, rs);
      chk(attention, 1'b1);
      chk(rxBits, b);
      chk(cmdComplete, 1'b1);
      axiRead(`CFGR_ADDR_STATUS, rd, rs);
      chk(rs, `CFGR_RESP_OKAY);
      chk({rd[5], rd[2:0]}, 4'b1101);
      axiWrite(`CFGR_ADDR_CTRL, 32'h00000001, rs);
      chk(attention, 1'b0);
    end
  endtask

  task automatic test_bps();
    axiWrite(`CFGR_ADDR_BPS, 32'd82, rs);
    chk(rs, `CFGR_RESP_OKAY);
    waitReady();
    spt = 16'd381;
    axiRead(`CFGR_ADDR_BPS, rd, rs);
    chk(rs, `CFGR_RESP_OKAY);
    chk(rd[15:0], spt);
    reqCfg(4'h6);
    reqCfg(4'h5);
  endtask

  task automatic test_unmapped();
    axiRead(12'h010, rd, rs);
    chk(rs, `CFGR_RESP_SLVERR);
    chk(rd, 32'h0);
    axiWrite(12'h010, 32'h0, rs);
    chk(rs, `CFGR_RESP_SLVERR);
  endtask

  // soft sector strap, motor option off
  task automatic test_soft();
    strapPins <= '{cylinders: 16'h0584, heads: 8'h0f, softSector: 1'b1, motorOpt: 1'b0,
      sptDefault: 8'h36};
    repeat (3) @(posedge core_clk);
    reqCfg(4'h0);
  endtask

  // watchdog
  initial begin
    #(50 * 20000);
    error_cnt++;
    final_report();
  end

  // main sequence
  initial begin
    rst_b = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'b00000;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    wstrb = 4'hf;
    spt = 16'd54;
    strapPins = '{cylinders: 16'h0584, heads: 8'h0f, softSector: 1'b0, motorOpt: 1'b1,
      sptDefault: 8'h36};
    repeat (6) @(posedge core_clk);
    test_reset();
    rst_b <= 1'b1;
    @(posedge core_clk);
    test_early();
    test_words();
    test_invalid();
    test_bps();
    test_soft();
    test_unmapped();
    final_report();
  end
endmodule
